// [dv/ccr_far_model.sv]
// far-end model: hub link and port targets answering forwarded reads
module ccr_far_model (
  // clock
  input  wire logic         clk_sys_in,
  // requests from the router
  input  wire ccr_pkg::ccr_fwd_t hub_req_in,
  input  wire ccr_pkg::ccr_fwd_t pcie_req_in,
  // read answers
  output logic      [31:0]  hub_rdata_out,
  output logic      [31:0]  pcie_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ccr_pkg::*;
  logic [31:0] noise_reg = 32'h0;
  // idle lines wander so a stale answer never matches by luck
  always_ff @(posedge clk_sys_in) begin
    noise_reg <= noise_reg + 32'h1357_9BDF;
  end
  // the hub decodes forwarded cycles itself and answers at once
  assign hub_rdata_out = (hub_req_in.valid && !hub_req_in.write) ?
                         ~hub_req_in.addr : noise_reg;
  assign pcie_rdata_out = (pcie_req_in.valid && !pcie_req_in.write) ?
                          ~pcie_req_in.addr : ~noise_reg;
endmodule

// [dv/ccr_router_test.sv]
// self-checking bench for the configuration cycle router
`define CHK(n, e, s) begin \
  cmp_count++; \
  if ((s) !== (e)) begin \
    n_fail++; \
    $display("wrong value %s exp %h got %h", n, e, s); \
  end \
end
module ccr_router_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ccr_pkg::*;
  localparam logic [15:0] VEND = 16'h2C4E; // arbitrary value
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        pg_n = 1'b0;
  logic [15:0] addr = 16'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  pop = 2'h3;
  logic [1:0]  trained = 2'h3;
  logic [7:0]  err = 8'h0;
  logic        strap = 1'b0;
  logic [31:0] rdata, hub_rdata, pcie_rdata, got;
  logic        abort, err_rep, got_ab;
  ccr_fwd_t    hub_req, pcie_req, got_hub, got_pcie;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  ccr_router #(.VENDOR_CODE(VEND)) ccr_router_i (
    .clk_sys_in(clk), .arst_n_in(arst_n), .pwrgood_rst_n_in(pg_n),
    .io_addr_in(addr), .io_be_in(be), .io_wdata_in(wdata),
    .io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdata),
    .io_abort_out(abort), .hub_req_out(hub_req),
    .hub_rdata_in(hub_rdata), .pcie_req_out(pcie_req),
    .pcie_rdata_in(pcie_rdata), .pcie_pop_in(pop),
    .pcie_trained_in(trained), .err_event_in(err),
    .strap_x8_in(strap), .err_report_out(err_rep));

  ccr_far_model ccr_far_model_i (
    .clk_sys_in(clk), .hub_req_in(hub_req), .pcie_req_in(pcie_req),
    .hub_rdata_out(hub_rdata), .pcie_rdata_out(pcie_rdata));

  task automatic results();
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  // one strobe, then capture everything the answer cycle carries
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [3:0] b, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
    got_ab = abort;
    got_hub = hub_req;
    got_pcie = pcie_req;
    @(posedge clk);
  endtask

  function automatic logic [31:0] ca(input logic [7:0] bus,
      input logic [4:0] dv, input logic [2:0] fn, input logic [5:0] r);
    return {1'b1, 7'h0, bus, dv, fn, r, 2'b00};
  endfunction

  task automatic rdcfg(input logic [31:0] c);
    io(1'b1, 16'h0CF8, 4'hF, c);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
  endtask

  task automatic wrcfg(input logic [31:0] c, input logic [31:0] d);
    io(1'b1, 16'h0CF8, 4'hF, c);
    io(1'b1, 16'h0CFC, 4'hF, d);
  endtask

  task automatic fwd(input logic [31:0] c, input logic pcie,
                     input ccr_kind_t k);
    ccr_fwd_t f;
    rdcfg(c);
    f = pcie ? got_pcie : got_hub;
    `CHK("fwd req", {1'b1, k, c}, {f.valid, f.kind, f.addr})
    `CHK("other req", 1'b0, pcie ? got_hub.valid : got_pcie.valid)
    `CHK("fwd rdata", ~c, got)
    `CHK("fwd lanes", {1'b0, 4'hF}, {f.write, f.be})
  endtask

  task automatic rst(input logic pg);
    arst_n <= 1'b0;
    pg_n <= !pg;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    pg_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic t_ids();
    rdcfg(ca(8'h0, 5'h0, 3'h0, 6'h0));
    `CHK("ids", {16'h3500, VEND}, got)
    io(1'b1, 16'h0CFC, 4'hF, 32'hFFFF_FFFF);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    `CHK("ids kept", {16'h3500, VEND}, got)
    rdcfg(ca(8'h0, 5'h2, 3'h0, 6'h02));
    `CHK("bridge class", 32'h0604_0001, got)
    rdcfg(ca(8'h0, 5'h8, 3'h0, 6'h0));
    `CHK("ext ids", {16'h3504, VEND}, got)
    rdcfg(ca(8'h0, 5'h0, 3'h0, 6'h38));
    `CHK("enable default", 32'h0000_000F, got)
  endtask

  task automatic t_route();
    io(1'b1, 16'h0CF8, 4'hF, ca(8'h0, 5'h2, 3'h0, 6'h06));
    io(1'b1, 16'h0CFC, 4'h6, 32'h0005_0200);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    `CHK("bus numbers", 32'h0005_0200, got)
    fwd(ca(8'h2, 5'h0, 3'h0, 6'h0), 1'b1, CCR_K_CFG0);
    `CHK("port a", 1'b0, got_pcie.port)
    fwd(ca(8'h5, 5'h0, 3'h0, 6'h0), 1'b1, CCR_K_CFG1);
    fwd(ca(8'h6, 5'h0, 3'h0, 6'h0), 1'b0, CCR_K_CFG1);
    fwd(ca(8'h1, 5'h0, 3'h0, 6'h0), 1'b0, CCR_K_CFG1);
    fwd(ca(8'h0, 5'h5, 3'h0, 6'h0), 1'b0, CCR_K_CFG0);
    wrcfg(ca(8'h0, 5'h3, 3'h0, 6'h06), 32'h0008_0800);
    fwd(ca(8'h8, 5'h0, 3'h0, 6'h0), 1'b1, CCR_K_CFG0);
    `CHK("port a1", 1'b1, got_pcie.port)
  endtask

  task automatic t_io();
    wrcfg(ca(8'h0, 5'h8, 3'h0, 6'h10), 32'h1122_3344);
    io(1'b1, 16'h0CF8, 4'h3, 32'h0000_1234);
    `CHK("narrow fwd", {1'b1, CCR_K_IO}, {got_hub.valid, got_hub.kind})
    `CHK("narrow addr", 32'h0000_0CF8, got_hub.addr)
    `CHK("narrow data", {1'b1, 4'h3, 32'h0000_1234},
         {got_hub.write, got_hub.be, got_hub.data})
    io(1'b1, 16'h0CFC, 4'h2, 32'hAABB_CCDD);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    `CHK("byte lanes", 32'h1122_CC44, got)
    io(1'b1, 16'h0CF8, 4'hF, 32'h0000_4000);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    `CHK("plain io", {1'b1, CCR_K_IO}, {got_hub.valid, got_hub.kind})
    `CHK("plain io data", 32'hFFFF_F303, got)
  endtask

  task automatic t_hide();
    rdcfg(ca(8'h0, 5'h3, 3'h0, 6'h0));
    `CHK("port a1 ids", {16'h3503, VEND}, got)
    wrcfg(ca(8'h0, 5'h0, 3'h0, 6'h38), 32'h0000_0007);
    rdcfg(ca(8'h0, 5'h8, 3'h0, 6'h0));
    `CHK("disabled read", {1'b1, 32'hFFFF_FFFF}, {got_ab, got})
    io(1'b1, 16'h0CFC, 4'hF, 32'h0);
    `CHK("disabled write", 2'b10, {got_ab, got_hub.valid})
    pop <= 2'h1;
    repeat (6) @(posedge clk);
    rdcfg(ca(8'h0, 5'h3, 3'h0, 6'h0));
    `CHK("empty port", {1'b1, 32'hFFFF_FFFF}, {got_ab, got})
    pop <= 2'h3;
    strap <= 1'b1;
    rst(1'b0);
    rdcfg(ca(8'h0, 5'h3, 3'h0, 6'h0));
    `CHK("wide port a", {1'b1, 32'hFFFF_FFFF}, {got_ab, got})
    strap <= 1'b0;
    rst(1'b0);
  endtask

  task automatic t_sticky();
    err <= 8'h01;
    repeat (6) @(posedge clk);
    err <= 8'h00;
    repeat (6) @(posedge clk);
    wrcfg(ca(8'h0, 5'h0, 3'h1, 6'h11), 32'h0000_0001);
    repeat (2) @(negedge clk);
    `CHK("error report", 1'b1, err_rep)
    @(posedge clk);
    rst(1'b0);
    rdcfg(ca(8'h0, 5'h0, 3'h1, 6'h10));
    `CHK("log kept", 32'h0000_0001, got)
    rdcfg(ca(8'h0, 5'h0, 3'h1, 6'h11));
    `CHK("command cleared", {1'b0, 32'h0}, {err_rep, got})
    rst(1'b1);
    rdcfg(ca(8'h0, 5'h0, 3'h1, 6'h10));
    `CHK("log cleared", 32'h0, got)
  endtask

  initial begin
    rst(1'b1);
    t_ids();
    t_route();
    t_io();
    t_hide();
    t_sticky();
    results();
  end
endmodule

// [hw/ccr_defs.svh]
// offsets, field positions, reset values and counts of the cycle router
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
`define CCR_IO_CADDR_W  14'h033E
`define CCR_IO_CDATA_W  14'h033F
`define CCR_CADDR_WMASK 32'h80FF_FFFC
`define CCR_CADDR_RST   32'h0000_0000
`define CCR_ALL_ONES    32'hFFFF_FFFF
`define CCR_EN_BIT      31
`define CCR_BUS_LO      16
`define CCR_DEV_LO      11
`define CCR_FN_LO       8
`define CCR_REG_LO      2
`define CCR_DEV_HUB     5'h00
`define CCR_DEV_PEA     5'h02
`define CCR_DEV_PEA1    5'h03
`define CCR_DEV_EXT     5'h08
`define CCR_OFF_ID      6'h00
`define CCR_OFF_CLASS   6'h02
`define CCR_OFF_HDR     6'h03
`define CCR_OFF_BUSNUM  6'h06
`define CCR_OFF_ERRLOG  6'h10
`define CCR_OFF_ERRCMD  6'h11
`define CCR_OFF_SCRATCH 6'h10
`define CCR_OFF_DEVEN   6'h38
`define CCR_OFF_STAT    6'h39
`define CCR_EN_FN1      0
`define CCR_EN_PEA      1
`define CCR_EN_PEA1     2
`define CCR_EN_EXT      3
`define CCR_SEC_LO      8
`define CCR_SUB_LO      16
`define CCR_PRIM_BUS    8'h00
`define CCR_BUS_RST     8'h00
`define CCR_DEVEN_RST   4'hF
`define CCR_ERRCMD_RST  8'h00
`define CCR_ERRLOG_RST  8'h00
`define CCR_DEVID_BASE  16'h3500
`define CCR_REV_CODE    8'h01
`define CCR_CLASS_HOST  24'h060000
`define CCR_CLASS_BRG   24'h060400
`define CCR_CLASS_OTHER 24'h088000
`define CCR_HDR_MULTI   8'h80
`define CCR_HDR_BRG     8'h01
`define CCR_HDR_PLAIN   8'h00
`define CCR_PIN_W       13
`define CCR_STRAP_CNT   3'h4
`endif

// [hw/ccr_pkg.sv]
// types shared by the configuration cycle router files
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_K_IO   = 2'b00,
    CCR_K_CFG0 = 2'b01,
    CCR_K_CFG1 = 2'b10
  } ccr_kind_t;

  typedef enum logic [2:0] {
    CCR_R_IO    = 3'b000,
    CCR_R_LOCAL = 3'b001,
    CCR_R_HIDE  = 3'b010,
    CCR_R_HUB   = 3'b011,
    CCR_R_PCIE  = 3'b100
  } ccr_route_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        port;
    ccr_kind_t   kind;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] data;
  } ccr_fwd_t;

  typedef struct packed {
    logic       strap_x8;
    logic [7:0] err;
    logic [1:0] trained;
    logic [1:0] pop;
  } ccr_pins_t;
endpackage

// [hw/ccr_router.sv]
// configuration cycle router: address latch, decode, local space, forwarding
// Function
// - reset loads defaults, some from straps
// - sticky error log survives hard reset
// - error log sticky, error command not
// - five identification fields are read-only
// - internal devices at 0.0, 0.1, 2, 3, 8
// - hidden device reads ones, drops writes
// - untrained or empty port hides its bridge
// - x8 port A hides port A1 bridge
// - disabled interface reads ones, aborts writes
// - eight functions, 256 bytes each
// - only address/data window mechanism exists
// - enable bit gates configuration cycles
// - data window maps to selected dword
// - bus field decoded, zero means bus 0
// - enabled internal targets never leave device
// - absent bus 0 devices go hub Type 0
// - unclaimed nonzero bus goes hub Type 1
// - bridge bus numbers steer port routing
// - secondary bus match gives port Type 0
// - deeper bus in range gives port Type 1
// - narrow address access passes as I/O
//
// The address-and-strobe port and the address map were chosen for this implementation.
`include "ccr_defs.svh"
module ccr_router #(
  parameter logic [15:0] VENDOR_CODE = 16'h1B5A // arbitrary value
) (
  // clock and resets
  input  wire logic               clk_sys_in,
  input  wire logic               arst_n_in,
  input  wire logic               pwrgood_rst_n_in,
  // host i/o port
  input  wire logic [15:0]        io_addr_in,
  input  wire logic [3:0]         io_be_in,
  input  wire logic [31:0]        io_wdata_in,
  input  wire logic               io_wr_in,
  input  wire logic               io_rd_in,
  output logic      [31:0]        io_rdata_out,
  output logic                    io_abort_out,
  // legacy hub link
  output ccr_pkg::ccr_fwd_t       hub_req_out,
  input  wire logic [31:0]        hub_rdata_in,
  // pci express ports
  output ccr_pkg::ccr_fwd_t       pcie_req_out,
  input  wire logic [31:0]        pcie_rdata_in,
  // pins
  input  wire logic [1:0]         pcie_pop_in,
  input  wire logic [1:0]         pcie_trained_in,
  input  wire logic [7:0]         err_event_in,
  input  wire logic               strap_x8_in,
  // error reporting
  output logic                    err_report_out
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [31:0] cfg_addr;
    logic [31:0] rdata;
    logic [1:0]  fwd_rd;
    logic        abort;
    ccr_fwd_t    hub;
    ccr_fwd_t    pcie;
    logic [3:0]  dev_en;
    logic [7:0]  err_cmd;
    logic [31:0] scratch;
    logic [2:0]  strap_cnt;
    logic        strap_done;
    logic        x8;
    logic        err_rep;
  } ccr_state_t;

  localparam ccr_state_t STATE_RST = '{
    cfg_addr: `CCR_CADDR_RST,
    hub:      '0,
    pcie:     '0,
    dev_en:   `CCR_DEVEN_RST,
    err_cmd:  `CCR_ERRCMD_RST,
    default:  '0
  };

  ccr_state_t  state_reg;
  ccr_state_t  state_next;
  logic [7:0]  err_log_reg;
  logic [7:0]  err_log_next;
  logic [7:0]  log_clr;
  ccr_pins_t   pins_raw;
  ccr_pins_t   pins_q;
  logic        is_ca;
  logic        is_cd;
  logic        acc;
  logic        cfge;
  logic [7:0]  bus;
  logic [4:0]  dev;
  logic [2:0]  fn;
  logic [5:0]  rix;
  logic [2:0]  lfn;
  logic        exists;
  logic        visible;
  logic        loc_wr;
  logic [1:0]  vis_br;
  logic [1:0]  br_hit;
  logic [1:0]  br_hit0;
  logic [1:0]  br_hit1;
  logic [1:0]  br_wr;
  logic [1:0][31:0] br_rd;
  logic [23:0] class_code;
  logic [7:0]  hdr_type;
  logic [31:0] loc_rd;
  ccr_route_t  route;
  ccr_fwd_t    fwd;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  assign pins_raw = {strap_x8_in, err_event_in, pcie_trained_in, pcie_pop_in};

  ccr_sync3 #(
    .W (`CCR_PIN_W)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .d_in       (pins_raw),
    .q_out      (pins_q)
  );

  // only the two dword ports of the address/data mechanism are claimed
  assign is_ca = (io_addr_in[15:2] == `CCR_IO_CADDR_W);
  assign is_cd = (io_addr_in[15:2] == `CCR_IO_CDATA_W);
  assign acc   = io_wr_in | io_rd_in;
  assign cfge  = state_reg.cfg_addr[`CCR_EN_BIT];
  assign bus   = state_reg.cfg_addr[`CCR_BUS_LO +: 8];
  assign dev   = state_reg.cfg_addr[`CCR_DEV_LO +: 5];
  assign fn    = state_reg.cfg_addr[`CCR_FN_LO +: 3];
  assign rix   = state_reg.cfg_addr[`CCR_REG_LO +: 6];

  assign vis_br[0] = state_reg.dev_en[`CCR_EN_PEA] & pins_q.pop[0] &
                     pins_q.trained[0];
  assign vis_br[1] = state_reg.dev_en[`CCR_EN_PEA1] & pins_q.pop[1] &
                     pins_q.trained[1] & ~state_reg.x8;
  assign br_hit    = (br_hit0 | br_hit1) & vis_br;

  // internal function map on bus 0
  always_comb begin
    lfn     = 3'h0;
    exists  = 1'b1;
    visible = 1'b1;
    if (dev == `CCR_DEV_HUB && fn == 3'h0) begin
      lfn = 3'h0;
    end else if (dev == `CCR_DEV_HUB && fn == 3'h1) begin
      lfn     = 3'h1;
      visible = state_reg.dev_en[`CCR_EN_FN1];
    end else if (dev == `CCR_DEV_PEA && fn == 3'h0) begin
      lfn     = 3'h2;
      visible = vis_br[0];
    end else if (dev == `CCR_DEV_PEA1 && fn == 3'h0) begin
      lfn     = 3'h3;
      visible = vis_br[1];
    end else if (dev == `CCR_DEV_EXT && fn == 3'h0) begin
      lfn     = 3'h4;
      visible = state_reg.dev_en[`CCR_EN_EXT];
    end else begin
      exists = 1'b0;
    end
  end

  always_comb begin
    route = CCR_R_IO;
    if (is_cd && cfge) begin
      if (bus == 8'h00) begin
        if (!exists) begin
          route = CCR_R_HUB;
        end else if (!visible) begin
          route = CCR_R_HIDE;
        end else begin
          route = CCR_R_LOCAL;
        end
      end else if (|br_hit) begin
        route = CCR_R_PCIE;
      end else begin
        route = CCR_R_HUB;
      end
    end
  end

  assign loc_wr   = io_wr_in && (route == CCR_R_LOCAL);
  assign br_wr[0] = loc_wr && (lfn == 3'h2) && (rix == `CCR_OFF_BUSNUM);
  assign br_wr[1] = loc_wr && (lfn == 3'h3) && (rix == `CCR_OFF_BUSNUM);

  for (genvar g = 0; g < 2; g++) begin : g_br
    ccr_vbridge u_br (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .wr_in      (br_wr[g]),
      .be_in      (io_be_in),
      .wdata_in   (io_wdata_in),
      .rd_out     (br_rd[g]),
      .bus_in     (bus),
      .hit0_out   (br_hit0[g]),
      .hit1_out   (br_hit1[g])
    );
  end

  // identification fields are constants, so writes cannot reach them
  always_comb begin
    if (lfn == 3'h2 || lfn == 3'h3) begin
      class_code = `CCR_CLASS_BRG;
      hdr_type   = `CCR_HDR_BRG;
    end else if (lfn == 3'h4) begin
      class_code = `CCR_CLASS_OTHER;
      hdr_type   = `CCR_HDR_PLAIN;
    end else begin
      class_code = `CCR_CLASS_HOST;
      hdr_type   = `CCR_HDR_MULTI;
    end
  end

  // unimplemented offsets of a present function read zero
  always_comb begin
    loc_rd = 32'h0000_0000;
    if (rix == `CCR_OFF_ID) begin
      loc_rd = {`CCR_DEVID_BASE | {13'h0000, lfn}, VENDOR_CODE};
    end else if (rix == `CCR_OFF_CLASS) begin
      loc_rd = {class_code, `CCR_REV_CODE};
    end else if (rix == `CCR_OFF_HDR) begin
      loc_rd = {8'h00, hdr_type, 16'h0000};
    end else if (lfn == 3'h0 && rix == `CCR_OFF_DEVEN) begin
      loc_rd = {28'h0000000, state_reg.dev_en};
    end else if (lfn == 3'h0 && rix == `CCR_OFF_STAT) begin
      loc_rd = {27'h0000000, state_reg.x8, pins_q.trained, pins_q.pop};
    end else if (lfn == 3'h1 && rix == `CCR_OFF_ERRLOG) begin
      loc_rd = {24'h000000, err_log_reg};
    end else if (lfn == 3'h1 && rix == `CCR_OFF_ERRCMD) begin
      loc_rd = {24'h000000, state_reg.err_cmd};
    end else if ((lfn == 3'h2 || lfn == 3'h3) &&
                 rix == `CCR_OFF_BUSNUM) begin
      loc_rd = br_rd[lfn[0]];
    end else if (lfn == 3'h4 && rix == `CCR_OFF_SCRATCH) begin
      loc_rd = state_reg.scratch;
    end
  end

  always_comb begin
    state_next            = state_reg;
    state_next.hub.valid  = 1'b0;
    state_next.pcie.valid = 1'b0;
    state_next.abort      = 1'b0;
    state_next.fwd_rd     = 2'b00;
    state_next.err_rep    = |(err_log_reg & state_reg.err_cmd);
    fwd = '{valid: 1'b1, write: io_wr_in, port: 1'b0, kind: CCR_K_CFG0,
            addr: state_reg.cfg_addr, be: io_be_in, data: io_wdata_in};
    // strap is taken one edge after the filtered pin is valid
    if (!state_reg.strap_done) begin
      state_next.strap_cnt = state_reg.strap_cnt + 3'h1;
      if (state_reg.strap_cnt == `CCR_STRAP_CNT) begin
        state_next.strap_done = 1'b1;
        state_next.x8         = pins_q.strap_x8;
      end
    end
    if (acc) begin
      case (route)
        CCR_R_IO: begin
          if (is_ca && io_be_in == 4'hF) begin
            if (io_wr_in) begin
              state_next.cfg_addr = io_wdata_in & `CCR_CADDR_WMASK;
            end else begin
              state_next.rdata = state_reg.cfg_addr;
            end
          end else begin
            fwd.kind            = CCR_K_IO;
            fwd.addr            = {16'h0000, io_addr_in};
            state_next.hub      = fwd;
            state_next.fwd_rd   = {1'b0, io_rd_in};
          end
        end
        CCR_R_LOCAL: begin
          if (io_rd_in) begin
            state_next.rdata = loc_rd;
          end else begin
            if (lfn == 3'h0 && rix == `CCR_OFF_DEVEN && io_be_in[0]) begin
              state_next.dev_en = io_wdata_in[3:0];
            end
            if (lfn == 3'h1 && rix == `CCR_OFF_ERRCMD && io_be_in[0]) begin
              state_next.err_cmd = io_wdata_in[7:0];
            end
            if (lfn == 3'h4 && rix == `CCR_OFF_SCRATCH) begin
              state_next.scratch = be_merge(state_reg.scratch,
                                            io_wdata_in, io_be_in);
            end
          end
        end
        CCR_R_HIDE: begin
          state_next.rdata = `CCR_ALL_ONES;
          state_next.abort = 1'b1;
        end
        CCR_R_HUB: begin
          fwd.kind          = (bus == 8'h00) ? CCR_K_CFG0 : CCR_K_CFG1;
          state_next.hub    = fwd;
          state_next.fwd_rd = {1'b0, io_rd_in};
        end
        default: begin
          // port A wins if software sets overlapping ranges
          fwd.port          = ~br_hit[0];
          fwd.kind          = br_hit0[fwd.port] ? CCR_K_CFG0 : CCR_K_CFG1;
          state_next.pcie   = fwd;
          state_next.fwd_rd = {io_rd_in, 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // error log keeps its own reset so a hard reset cannot wipe it
  assign log_clr = (loc_wr && lfn == 3'h1 && rix == `CCR_OFF_ERRLOG &&
                    io_be_in[0]) ? io_wdata_in[7:0] : 8'h00;
  assign err_log_next = (err_log_reg & ~log_clr) | pins_q.err;

  always_ff @(posedge clk_sys_in or negedge pwrgood_rst_n_in) begin
    if (!pwrgood_rst_n_in) begin
      err_log_reg <= `CCR_ERRLOG_RST;
    end else begin
      err_log_reg <= err_log_next;
    end
  end

  // far-end answers pass straight through in the answer cycle
  assign io_rdata_out   = state_reg.fwd_rd[0] ? hub_rdata_in :
                          state_reg.fwd_rd[1] ? pcie_rdata_in :
                          state_reg.rdata;
  assign io_abort_out   = state_reg.abort;
  assign hub_req_out    = state_reg.hub;
  assign pcie_req_out   = state_reg.pcie;
  assign err_report_out = state_reg.err_rep;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_narrow_ca;
    acc && is_ca && io_be_in != 4'hF;
  endsequence

  sequence s_io_out;
    hub_req_out.valid && hub_req_out.kind == CCR_K_IO && !pcie_req_out.valid;
  endsequence

  property p_local_read;
    logic [31:0] v;
    (io_rd_in && route == CCR_R_LOCAL, v = loc_rd) |=> io_rdata_out == v;
  endproperty

  a_narrow_ca: assert property (
    s_narrow_ca |=> s_io_out ##0 $stable(state_reg.cfg_addr))
    else $error("narrow address access not passed as i/o");

  a_window_off: assert property (
    (acc && is_cd && !cfge) |=> s_io_out)
    else $error("window used while enable bit clear");

  a_hide_ones: assert property (
    (io_rd_in && route == CCR_R_HIDE) |=>
      io_rdata_out == `CCR_ALL_ONES && io_abort_out ##1
      (!io_abort_out || $past(acc && route == CCR_R_HIDE)))
    else $error("hidden device did not read all ones");

  a_local_only: assert property (
    (acc && route == CCR_R_LOCAL) |=> !hub_req_out.valid &&
      !pcie_req_out.valid)
    else $error("internal access leaked outward");

  a_local_read: assert property (p_local_read)
    else $error("window read data wrong");

  a_hub_type1: assert property (
    (acc && route == CCR_R_HUB && bus != 8'h00) |=>
      hub_req_out.valid && hub_req_out.kind == CCR_K_CFG1)
    else $error("unclaimed bus not sent as type 1");

  a_port_type0: assert property (
    (acc && cfge && is_cd && bus != 8'h00 && br_hit0[0] && vis_br[0]) |=>
      pcie_req_out.valid && !pcie_req_out.port &&
      pcie_req_out.kind == CCR_K_CFG0)
    else $error("secondary match not sent as type 0");

  a_strap_time: assert property (
    $rose(arst_n_in) |-> ##[1:6] state_reg.strap_done)
    else $error("strap not captured after reset");

  a_sticky_log: assert property (
    @(posedge clk_sys_in) disable iff (!pwrgood_rst_n_in)
    !arst_n_in |=> (err_log_reg | ~$past(err_log_reg)) == 8'hFF)
    else $error("error log lost during hard reset");
endmodule

// [hw/ccr_sync3.sv]
// three-flop pin synchroniser that accepts a change once stages agree
module ccr_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         arst_n_in,
  // pins in, filtered levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ccr_sync_t;

  ccr_sync_t    state_reg;
  ccr_sync_t    state_next;
  logic [W-1:0] agree;

  // s1 feeds only s2; the filter looks at s2 and s3 alone
  assign agree = ~(state_reg.s2 ^ state_reg.s3);

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = d_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.q  = (agree & state_reg.s3) | (~agree & state_reg.q);
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_out = state_reg.q;

  a_sync_agree: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ((state_reg.q ^ $past(state_reg.q)) &
     $past(state_reg.s2 ^ state_reg.s3)) == '0)
    else $error("filtered pin moved while stages disagreed");
endmodule

// [hw/ccr_vbridge.sv]
// virtual bridge bus-number registers and downstream range decode
`include "ccr_defs.svh"
module ccr_vbridge (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // register access
  input  wire logic        wr_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] rd_out,
  // range decode
  input  wire logic [7:0]  bus_in,
  output logic             hit0_out,
  output logic             hit1_out
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] sub;
  } ccr_vb_t;

  ccr_vb_t state_reg;
  ccr_vb_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_in && be_in[1]) begin
      state_next.sec = wdata_in[`CCR_SEC_LO +: 8];
    end
    if (wr_in && be_in[2]) begin
      state_next.sub = wdata_in[`CCR_SUB_LO +: 8];
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= '{sec: `CCR_BUS_RST, sub: `CCR_BUS_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  // primary side always sits on bus 0, so that byte is fixed
  assign rd_out = {8'h00, state_reg.sub, state_reg.sec, `CCR_PRIM_BUS};
  assign hit0_out = (bus_in != 8'h00) && (bus_in == state_reg.sec);
  assign hit1_out = (bus_in != 8'h00) && (bus_in > state_reg.sec) &&
                    (bus_in <= state_reg.sub);

  a_sec_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && be_in[1]) |=> (rd_out[15:8] == $past(wdata_in[15:8])) &&
                           (rd_out[7:0] == 8'h00))
    else $error("secondary bus number not taken from write");
endmodule
